// *** hdl/abx_pkg.sv ***
// Package: constants, types and decode for the accumulator and bit-op execution block
package abx_pkg;

	// ****************************************
	// Widths
	// ****************************************
	localparam int DATA_W = 8;
	localparam int FADR_W = 7;
	localparam int OPC_W = 14;
	localparam int WB_ADR_W = 12;
	localparam int FILE_DEPTH_DOC = 128;

	// ****************************************
	// Bus register map (byte addresses)
	// ****************************************
	localparam logic [11:0] ADR_INSTR = 12'h000;
	localparam logic [11:0] ADR_ACC = 12'h004;
	localparam logic [11:0] ADR_STATUS = 12'h008;
	localparam logic [2:0] ADR_FILE_SEL = 3'h1;
	localparam int FILE_IDX_LSB = 2;
	localparam int FILE_IDX_MSB = 8;

	// ****************************************
	// Status register fields
	// ****************************************
	localparam int ST_C = 0;
	localparam int ST_DC = 1;
	localparam int ST_Z = 2;
	localparam int ST_SKIP = 3;
	localparam int ST_ILL = 4;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [7:0] ACC_RST = 8'h00;
	localparam logic [13:0] INSTR_RST = 14'h0000;
	localparam logic [7:0] LATCH_RST = 8'h00;

	// ****************************************
	// Opcode fields
	// ****************************************
	localparam int OPC_D_BIT = 7;
	localparam int OPC_B_LSB = 7;
	localparam int OPC_B_MSB = 9;
	localparam int OPC_F_MSB = 6;
	localparam logic [5:0] PAT_ADD_FILE = 6'h07;
	localparam logic [5:0] PAT_AND_FILE = 6'h05;
	localparam logic [5:0] PAT_AND_LIT = 6'h39;
	localparam logic [4:0] PAT_ADD_LIT = 5'h1F;
	localparam logic [3:0] PAT_BIT_CLR = 4'h4;
	localparam logic [3:0] PAT_BIT_SET = 4'h5;
	localparam logic [3:0] PAT_SKIP_ZERO = 4'h6;
	localparam logic [3:0] PAT_SKIP_ONE = 4'h7;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [3:0] {
		OP_NONE,
		OP_ADD_LITERAL_TO_ACC,
		OP_ADD_ACC_AND_FILE,
		OP_AND_LITERAL_WITH_ACC,
		OP_AND_ACC_WITH_FILE,
		OP_FILE_BIT_CLEAR,
		OP_FILE_BIT_SET,
		OP_TEST_BIT_SKIP_WHEN_ONE,
		OP_TEST_BIT_SKIP_WHEN_ZERO
	} abx_op_t;

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_OPRD = 4'b0010,
		ST_BUSRD = 4'b0100,
		ST_ACK = 4'b1000
	} abx_state_t;

	function automatic abx_op_t abx_decode(input logic [13:0] opc);
		abx_op_t op;
		op = OP_NONE;
		if (opc[13:9] == PAT_ADD_LIT) begin
			op = OP_ADD_LITERAL_TO_ACC;
		end else if (opc[13:8] == PAT_AND_LIT) begin
			op = OP_AND_LITERAL_WITH_ACC;
		end else if (opc[13:8] == PAT_ADD_FILE) begin
			op = OP_ADD_ACC_AND_FILE;
		end else if (opc[13:8] == PAT_AND_FILE) begin
			op = OP_AND_ACC_WITH_FILE;
		end else if (opc[13:10] == PAT_BIT_CLR) begin
			op = OP_FILE_BIT_CLEAR;
		end else if (opc[13:10] == PAT_BIT_SET) begin
			op = OP_FILE_BIT_SET;
		end else if (opc[13:10] == PAT_SKIP_ZERO) begin
			op = OP_TEST_BIT_SKIP_WHEN_ZERO;
		end else if (opc[13:10] == PAT_SKIP_ONE) begin
			op = OP_TEST_BIT_SKIP_WHEN_ONE;
		end
		return op;
	endfunction

endpackage

// *** hdl/abx_alu_if.sv ***
// Interface between the sequencer and the arithmetic unit
`timescale 1ns/1ps
`default_nettype none
interface abx_alu_if;
	abx_pkg::abx_op_t op;
	logic [7:0] acc;
	logic [7:0] opnd;
	logic [7:0] lit;
	logic [2:0] bitsel;
	logic dest_file;
	logic [7:0] result;
	logic c;
	logic dc;
	logic z;
	logic upd_cdc;
	logic upd_z;
	logic wr_acc;
	logic wr_file;
	logic skip;

	modport core (output op, acc, opnd, lit, bitsel, dest_file,
		input result, c, dc, z, upd_cdc, upd_z, wr_acc, wr_file, skip);
	modport alu (input op, acc, opnd, lit, bitsel, dest_file,
		output result, c, dc, z, upd_cdc, upd_z, wr_acc, wr_file, skip);
endinterface
`default_nettype wire

// *** hdl/abx_file_mem.sv ***
// File register memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module abx_file_mem #(
	parameter int DEPTH = 128,
	parameter int WIDTH = 8,
	parameter int AW = 7
) (
	input wire logic core_clk,
	input wire logic ce,
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [WIDTH-1:0] wdata,
	input wire logic re,
	input wire logic [AW-1:0] raddr,
	output logic [WIDTH-1:0] rdata_r
);
	logic [WIDTH-1:0] mem [DEPTH];

	if (DEPTH > (1 << AW)) begin : g_chk
		$error("abx_file_mem: depth exceeds address range");
	end

	always_ff @(posedge core_clk) begin
		if (ce && we) begin
			mem[waddr] <= wdata;
		end
	end

	always_ff @(posedge core_clk) begin
		if (ce && re) begin
			rdata_r <= mem[raddr];
		end
	end
endmodule // abx_file_mem
`default_nettype wire

// *** hdl/abx_alu.sv ***
// Arithmetic, logic and bit unit for the eight supported instructions
`timescale 1ns/1ps
`default_nettype none
module abx_alu (
	abx_alu_if.alu a
);
	logic [8:0] sum;
	logic [4:0] low_sum;
	logic [7:0] mask;
	logic tbit;

	always_comb begin
		sum = {1'b0, a.acc} + {1'b0, a.opnd};
		low_sum = {1'b0, a.acc[3:0]} + {1'b0, a.opnd[3:0]};
		if (a.op == abx_pkg::OP_ADD_LITERAL_TO_ACC) begin
			sum = {1'b0, a.acc} + {1'b0, a.lit};
			low_sum = {1'b0, a.acc[3:0]} + {1'b0, a.lit[3:0]};
		end
		mask = 8'h01 << a.bitsel;
		tbit = a.opnd[a.bitsel];
		a.result = 8'h00;
		a.upd_cdc = 1'b0;
		a.upd_z = 1'b0;
		a.wr_acc = 1'b0;
		a.wr_file = 1'b0;
		a.skip = 1'b0;
		unique case (a.op)
			abx_pkg::OP_ADD_LITERAL_TO_ACC: begin
				a.result = sum[7:0];
				a.upd_cdc = 1'b1;
				a.upd_z = 1'b1;
				a.wr_acc = 1'b1;
			end
			abx_pkg::OP_ADD_ACC_AND_FILE: begin
				a.result = sum[7:0];
				a.upd_cdc = 1'b1;
				a.upd_z = 1'b1;
				a.wr_acc = !a.dest_file;
				a.wr_file = a.dest_file;
			end
			abx_pkg::OP_AND_LITERAL_WITH_ACC: begin
				a.result = a.acc & a.lit;
				a.upd_z = 1'b1;
				a.wr_acc = 1'b1;
			end
			abx_pkg::OP_AND_ACC_WITH_FILE: begin
				a.result = a.acc & a.opnd;
				a.upd_z = 1'b1;
				a.wr_acc = !a.dest_file;
				a.wr_file = a.dest_file;
			end
			abx_pkg::OP_FILE_BIT_CLEAR: begin
				a.result = a.opnd & ~mask;
				a.wr_file = 1'b1;
			end
			abx_pkg::OP_FILE_BIT_SET: begin
				a.result = a.opnd | mask;
				a.wr_file = 1'b1;
			end
			abx_pkg::OP_TEST_BIT_SKIP_WHEN_ONE: begin
				a.skip = tbit;
			end
			abx_pkg::OP_TEST_BIT_SKIP_WHEN_ZERO: begin
				a.skip = !tbit;
			end
			abx_pkg::OP_NONE: begin
				a.result = 8'h00;
			end
		endcase
	end

	assign a.c = sum[8];
	assign a.dc = low_sum[4];
	assign a.z = (a.result == 8'h00);
endmodule // abx_alu
`default_nettype wire

// *** hdl/abx_exec_top.sv ***
// Top of the accumulator and bit-op execution block with a Wishbone register slave
// Notes on behaviour
// - Literal add: acc plus 8-bit literal into acc, updates carry, digit carry, zero.
// - File add: acc plus file f (0..127) to acc if d=0, to f if d=1.
// - Literal AND: acc AND literal into acc, only zero flag changes.
// - File AND: acc AND f to acc or f by d, only zero flag changes.
// - Bit clear: bit b of f forced to zero, flags and other bits kept.
// - Bit set: bit b of f forced to one, flags and other bits kept.
// - Skip when one: bit set discards next instruction as a no-op, two cycles.
// - Skip when zero: bit clear discards next instruction as a no-op, two cycles.
// - Bit tests change no flag and no register, only the skip.
// - Port register operands are read from the pins, not the output latch.
// - Destination bit 0 targets the accumulator, 1 targets file register f.
//
// The implementer's own choices: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module abx_exec_top #(
	parameter int FILE_DEPTH = 128,
	parameter logic [6:0] PORT_ADDR = 7'h06
) (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic ce,
	input wire logic wb_cyc,
	input wire logic wb_stb,
	input wire logic wb_we,
	input wire logic [11:0] wb_adr,
	input wire logic [3:0] wb_sel,
	input wire logic [31:0] wb_dat_w,
	output logic [31:0] wb_dat_r,
	output logic wb_ack,
	input wire logic [7:0] port_pins,
	output logic [7:0] port_latch
);

	// ****************************************
	// Parameter check
	// ****************************************
	if (FILE_DEPTH != abx_pkg::FILE_DEPTH_DOC || int'(PORT_ADDR) >= FILE_DEPTH) begin : g_chk
		$error("abx_exec_top: file depth must be 128 and port address inside it");
	end

	// ****************************************
	// Declarations
	// ****************************************
	abx_pkg::abx_state_t state_r, state_nxt;
	abx_pkg::abx_op_t op;
	logic [7:0] acc_r;
	logic flag_c_r;
	logic flag_dc_r;
	logic flag_z_r;
	logic skip_r;
	logic ill_r;
	logic [13:0] instr_r;
	logic [13:0] instr_new;
	logic [13:0] cur_opc;
	logic [7:0] port_latch_r;
	logic [31:0] dat_r_r;
	logic [31:0] rd_val;
	logic req;
	logic adr_instr;
	logic adr_acc;
	logic adr_status;
	logic adr_file;
	logic [6:0] bus_fidx;
	logic instr_go;
	logic needs_file;
	logic exec_now;
	logic mem_we;
	logic [6:0] mem_waddr;
	logic [7:0] mem_wdata;
	logic mem_re;
	logic [6:0] mem_raddr;
	logic [7:0] mem_rdata;
	logic [7:0] opnd;
	logic [7:0] bus_file_val;

	abx_alu_if alu_bus ();

	// ****************************************
	// Address decode and request qualification
	// ****************************************
	assign req = wb_cyc && wb_stb && (state_r == abx_pkg::ST_IDLE);
	assign adr_instr = (wb_adr == abx_pkg::ADR_INSTR);
	assign adr_acc = (wb_adr == abx_pkg::ADR_ACC);
	assign adr_status = (wb_adr == abx_pkg::ADR_STATUS);
	assign adr_file = (wb_adr[11:9] == abx_pkg::ADR_FILE_SEL) && (wb_adr[1:0] == 2'h0);
	assign bus_fidx = wb_adr[abx_pkg::FILE_IDX_MSB:abx_pkg::FILE_IDX_LSB];

	// Lane-merged opcode for a write to the instruction register
	assign instr_new = {wb_sel[1] ? wb_dat_w[13:8] : instr_r[13:8],
		wb_sel[0] ? wb_dat_w[7:0] : instr_r[7:0]};
	assign instr_go = req && wb_we && adr_instr && (wb_sel[1:0] != 2'h0);

	// ****************************************
	// Decode and execution timing
	// ****************************************
	assign cur_opc = (state_r == abx_pkg::ST_OPRD) ? instr_r : instr_new;
	assign op = abx_pkg::abx_decode(cur_opc);
	assign needs_file = (op != abx_pkg::OP_NONE) &&
		(op != abx_pkg::OP_ADD_LITERAL_TO_ACC) &&
		(op != abx_pkg::OP_AND_LITERAL_WITH_ACC);

	assign exec_now = (instr_go && !skip_r && !needs_file) || (state_r == abx_pkg::ST_OPRD);

	assign opnd = (instr_r[abx_pkg::OPC_F_MSB:0] == PORT_ADDR) ? port_pins : mem_rdata;
	assign bus_file_val = (bus_fidx == PORT_ADDR) ? port_pins : mem_rdata;

	// ****************************************
	// Arithmetic unit hookup
	// ****************************************
	assign alu_bus.op = exec_now ? op : abx_pkg::OP_NONE;
	assign alu_bus.acc = acc_r;
	assign alu_bus.opnd = opnd;
	assign alu_bus.lit = cur_opc[7:0];
	assign alu_bus.bitsel = cur_opc[abx_pkg::OPC_B_MSB:abx_pkg::OPC_B_LSB];
	assign alu_bus.dest_file = cur_opc[abx_pkg::OPC_D_BIT];

	abx_alu u_alu (
		.a(alu_bus.alu)
	);

	// ****************************************
	// File register memory
	// ****************************************
	assign mem_we = (exec_now && alu_bus.wr_file) ||
		(req && wb_we && adr_file && wb_sel[0]);
	assign mem_waddr = exec_now ? instr_r[abx_pkg::OPC_F_MSB:0] : bus_fidx;
	assign mem_wdata = exec_now ? alu_bus.result : wb_dat_w[7:0];
	assign mem_re = req && ((instr_go && !skip_r && needs_file) || (!wb_we && adr_file));
	assign mem_raddr = instr_go ? instr_new[abx_pkg::OPC_F_MSB:0] : bus_fidx;

	abx_file_mem #(
		.DEPTH(FILE_DEPTH),
		.WIDTH(abx_pkg::DATA_W),
		.AW(abx_pkg::FADR_W)
	) u_mem (
		.core_clk(core_clk),
		.ce(ce),
		.we(mem_we),
		.waddr(mem_waddr),
		.wdata(mem_wdata),
		.re(mem_re),
		.raddr(mem_raddr),
		.rdata_r(mem_rdata)
	);

	// ****************************************
	// Sequencer
	// ****************************************
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			abx_pkg::ST_IDLE: begin
				if (req) begin
					if (mem_re && instr_go) begin
						state_nxt = abx_pkg::ST_OPRD;
					end else if (mem_re) begin
						state_nxt = abx_pkg::ST_BUSRD;
					end else begin
						state_nxt = abx_pkg::ST_ACK;
					end
				end
			end
			abx_pkg::ST_OPRD: begin
				state_nxt = abx_pkg::ST_ACK;
			end
			abx_pkg::ST_BUSRD: begin
				state_nxt = abx_pkg::ST_ACK;
			end
			abx_pkg::ST_ACK: begin
				state_nxt = abx_pkg::ST_IDLE;
			end
			default: begin
				state_nxt = abx_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			state_r <= abx_pkg::ST_IDLE;
		end else if (ce) begin
			state_r <= state_nxt;
		end
	end

	assign wb_ack = (state_r == abx_pkg::ST_ACK);

	// ****************************************
	// Instruction register
	// ****************************************
	always_ff @(posedge core_clk) begin
		if (srst) begin
			instr_r <= abx_pkg::INSTR_RST;
		end else if (ce && instr_go) begin
			instr_r <= instr_new;
		end
	end

	// ****************************************
	// Accumulator
	// ****************************************
	always_ff @(posedge core_clk) begin
		if (srst) begin
			acc_r <= abx_pkg::ACC_RST;
		end else if (ce) begin
			if (exec_now && alu_bus.wr_acc) begin
				acc_r <= alu_bus.result;
			end else if (req && wb_we && adr_acc && wb_sel[0]) begin
				acc_r <= wb_dat_w[7:0];
			end
		end
	end

	// ****************************************
	// Status flags
	// ****************************************
	// tests leave flags alone
	always_ff @(posedge core_clk) begin
		if (srst) begin
			flag_c_r <= 1'b0;
			flag_dc_r <= 1'b0;
			flag_z_r <= 1'b0;
		end else if (ce) begin
			if (exec_now && alu_bus.upd_cdc) begin
				flag_c_r <= alu_bus.c;
				flag_dc_r <= alu_bus.dc;
			end else if (req && wb_we && adr_status && wb_sel[0]) begin
				flag_c_r <= wb_dat_w[abx_pkg::ST_C];
				flag_dc_r <= wb_dat_w[abx_pkg::ST_DC];
			end
			if (exec_now && alu_bus.upd_z) begin
				flag_z_r <= alu_bus.z;
			end else if (req && wb_we && adr_status && wb_sel[0]) begin
				flag_z_r <= wb_dat_w[abx_pkg::ST_Z];
			end
		end
	end

	// Unsupported opcode marker, write one to clear, a new event wins
	always_ff @(posedge core_clk) begin
		if (srst) begin
			ill_r <= 1'b0;
		end else if (ce) begin
			if (instr_go && !skip_r && op == abx_pkg::OP_NONE) begin
				ill_r <= 1'b1;
			end else if (req && wb_we && adr_status && wb_sel[0] && wb_dat_w[abx_pkg::ST_ILL]) begin
				ill_r <= 1'b0;
			end
		end
	end

	// ****************************************
	// Skip of the following instruction
	// ****************************************
	// discard next instruction
	always_ff @(posedge core_clk) begin
		if (srst) begin
			skip_r <= 1'b0;
		end else if (ce) begin
			if (exec_now && alu_bus.skip) begin
				skip_r <= 1'b1;
			end else if (instr_go && skip_r) begin
				skip_r <= 1'b0;
			end
		end
	end

	// ****************************************
	// Port output latch
	// ****************************************
	always_ff @(posedge core_clk) begin
		if (srst) begin
			port_latch_r <= abx_pkg::LATCH_RST;
		end else if (ce && mem_we && mem_waddr == PORT_ADDR) begin
			port_latch_r <= mem_wdata;
		end
	end

	assign port_latch = port_latch_r;

	// ****************************************
	// Read data
	// ****************************************
	always_comb begin
		rd_val = 32'h00000000;
		if (state_r == abx_pkg::ST_BUSRD) begin
			rd_val[7:0] = bus_file_val;
		end else if (adr_instr) begin
			rd_val[13:0] = instr_r;
		end else if (adr_acc) begin
			rd_val[7:0] = acc_r;
		end else if (adr_status) begin
			rd_val[abx_pkg::ST_C] = flag_c_r;
			rd_val[abx_pkg::ST_DC] = flag_dc_r;
			rd_val[abx_pkg::ST_Z] = flag_z_r;
			rd_val[abx_pkg::ST_SKIP] = skip_r;
			rd_val[abx_pkg::ST_ILL] = ill_r;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			dat_r_r <= 32'h00000000;
		end else if (ce && state_nxt == abx_pkg::ST_ACK && !wb_we) begin
			dat_r_r <= rd_val;
		end
	end

	assign wb_dat_r = dat_r_r;

endmodule // abx_exec_top
`default_nettype wire

// *** bench/abx_exec_asserts.sv ***
// Port checks of the execution block
`timescale 1ns/1ps
`default_nettype none
module abx_exec_asserts #(
	parameter logic [6:0] PORT_ADDR = 7'h06
) (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic ce,
	input wire logic wb_cyc,
	input wire logic wb_stb,
	input wire logic wb_we,
	input wire logic [11:0] wb_adr,
	input wire logic [3:0] wb_sel,
	input wire logic [31:0] wb_dat_w,
	input wire logic [31:0] wb_dat_r,
	input wire logic wb_ack,
	input wire logic [7:0] port_pins,
	input wire logic [7:0] port_latch
);
	// ****
	// Helpers
	// ****
	logic req;
	logic bop;
	logic [7:0] msk;
	assign req = wb_cyc && wb_stb;
	assign bop = wb_ack && wb_we && wb_adr == abx_pkg::ADR_INSTR && wb_sel[1:0] == 2'h3
		&& wb_dat_w[6:0] == PORT_ADDR;
	assign msk = 8'h01 << wb_dat_w[9:7];
	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);
	// ****
	// Assertions
	// ****
	AST_ACK_PULSE: assert property (wb_ack && ce |=> !wb_ack)
		else $error("ack held too long");
	AST_ACK_BOUND: assert property ($rose(req) |-> ##[1:2] wb_ack)
		else $error("ack late");
	AST_ACK_CAUSE: assert property (wb_ack |-> $past(req))
		else $error("ack without request");
	AST_RESET: assert property (disable iff (1'b0) srst |=> !wb_ack && wb_dat_r == 32'h0
		&& port_latch == 8'h00) else $error("reset state wrong");
	AST_PORT_SET: assert property (bop && wb_dat_w[13:10] == abx_pkg::PAT_BIT_SET
		&& $past(wb_stb, 2) |-> port_latch == ($past(port_pins) | msk))
		else $error("port bit set wrong");
	AST_PORT_CLR: assert property (bop && wb_dat_w[13:10] == abx_pkg::PAT_BIT_CLR
		&& $past(wb_stb, 2) |-> port_latch == ($past(port_pins) & ~msk))
		else $error("port bit clear wrong");
	AST_LATCH_HOLD: assert property (!wb_ack |-> $stable(port_latch))
		else $error("latch moved outside ack");
	AST_DAT_HOLD: assert property ($changed(wb_dat_r) |-> wb_ack && !wb_we)
		else $error("read data moved");
	cover property ($rose(req) ##2 wb_ack);
	cover property (bop && $past(wb_stb, 2));
	cover property ($rose(req) ##1 wb_ack);
endmodule // abx_exec_asserts
bind abx_exec_top abx_exec_asserts #(.PORT_ADDR(PORT_ADDR)) abx_exec_asserts_i (
	.core_clk(core_clk), .srst(srst), .ce(ce), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
	.wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w),
	.wb_dat_r(wb_dat_r), .wb_ack(wb_ack), .port_pins(port_pins), .port_latch(port_latch));
`default_nettype wire

// *** bench/accumulator_bit_op_exec_test.sv ***
// Self-checking bench of the execution block
`timescale 1ns/1ps
`default_nettype none
module accumulator_bit_op_exec_test;
	localparam logic [6:0] PA = 7'h06;
	typedef struct {logic [11:0] a; logic [31:0] v;} abx_exp_t;
	logic core_clk = 1'b0;
	logic srst = 1'b1;
	logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
	logic [11:0] wb_adr = 12'h000;
	logic [3:0] wb_sel = 4'h0;
	logic [31:0] wb_dat_w = 32'h0;
	logic [31:0] wb_dat_r;
	logic wb_ack;
	logic [7:0] port_pins = 8'h00;
	logic [7:0] port_latch;
	logic [7:0] acc = 8'h00, lat = 8'h00, pins = 8'h00, rnd = 8'h3D;
	logic c = 1'b0, dc = 1'b0, z = 1'b0, skp = 1'b0;
	logic [7:0] fm [128];
	logic [6:0] fl [4] = '{7'h00, PA, 7'h10, 7'h7F};
	abx_exp_t q [$];
	int err_total = 0, cmp_count = 0, cyc_n = 0;
	abx_exec_top #(.FILE_DEPTH(128), .PORT_ADDR(PA)) abx_exec_top_i (
		.core_clk(core_clk), .srst(srst), .ce(1'b1), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
		.wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w),
		.wb_dat_r(wb_dat_r), .wb_ack(wb_ack), .port_pins(port_pins), .port_latch(port_latch));
	// ****
	// Clock, timeout, verdict
	// ****
	initial begin
		forever #5 core_clk = ~core_clk;
	end
	task automatic print_verdict();
		$display("compares %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	always @(posedge core_clk) begin
		cyc_n <= cyc_n + 1;
		if (cyc_n == 20000) begin
			err_total = err_total + 1;
			print_verdict();
		end
	end
	// ****
	// Helpers
	// ****
	function automatic logic [7:0] nx(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	function automatic logic [11:0] fa(input logic [6:0] f);
		return {abx_pkg::ADR_FILE_SEL, f, 2'h0};
	endfunction
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	// Takes the oldest expected read when an answer arrives
	always @(posedge core_clk) begin
		abx_exp_t x;
		if (wb_ack === 1'b1 && wb_we === 1'b0 && q.size() > 0) begin
			x = q.pop_front();
			chk($sformatf("read %h", x.a), x.v, wb_dat_r);
		end
	end
	task automatic bus(input logic we, input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= a;
		wb_dat_w <= d;
		wb_sel <= s;
		@(posedge core_clk);
		while (wb_ack !== 1'b1) begin
			@(posedge core_clk);
		end
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		q.push_back('{a, e});
		bus(1'b0, a, 32'h0, 4'hF);
	endtask
	task automatic wrf(input logic [6:0] f, input logic [7:0] r);
		fm[f] = r;
		if (f == PA) begin
			lat = r;
		end
	endtask
	task automatic chkall(input logic [6:0] f);
		rd(abx_pkg::ADR_ACC, {24'h0, acc});
		rd(abx_pkg::ADR_STATUS, {27'h0, 1'b0, skp, z, dc, c});
		rd(fa(f), {24'h0, (f == PA) ? pins : fm[f]});
		chk("latch", {24'h0, lat}, {24'h0, port_latch});
	endtask
	// Executes one opcode and moves the reference state alongside
	task automatic ins(input logic [13:0] o);
		logic [7:0] fv, op, r;
		logic [8:0] s;
		logic [4:0] n;
		logic ad;
		rnd = nx(rnd);
		pins = rnd;
		port_pins <= rnd;
		fv = (o[6:0] == PA) ? pins : fm[o[6:0]];
		op = o[13] ? o[7:0] : fv;
		s = acc + op;
		n = acc[3:0] + op[3:0];
		ad = o[13] ? o[10] : o[9];
		bus(1'b1, abx_pkg::ADR_INSTR, {18'h0, o}, 4'hF);
		if (skp) begin
			skp = 1'b0;
		end else if (!o[13] && o[12]) begin
			r = fv;
			r[o[9:7]] = o[10];
			if (o[11]) begin
				skp = fv[o[9:7]] == o[10];
			end else begin
				wrf(o[6:0], r);
			end
		end else begin
			r = ad ? s[7:0] : (acc & op);
			z = r == 8'h00;
			if (ad) begin
				c = s[8];
				dc = n[4];
			end
			if (o[13] || !o[7]) begin
				acc = r;
			end else begin
				wrf(o[6:0], r);
			end
		end
	endtask
	// ****
	// Main sequence
	// ****
	initial begin
		logic [13:0] o;
		logic [7:0] x;
		logic [6:0] f;
		repeat (6) @(posedge core_clk);
		srst <= 1'b0;
		@(posedge core_clk);
		chk("latch reset", 32'h0, {24'h0, port_latch});
		rd(abx_pkg::ADR_ACC, 32'h0);
		rd(abx_pkg::ADR_STATUS, 32'h0);
		rd(12'h040, 32'h0);
		bus(1'b1, 12'h040, 32'hFF, 4'hF);
		for (int j = 0; j < 4; j++) begin
			rnd = nx(rnd);
			wrf(fl[j], rnd);
			bus(1'b1, fa(fl[j]), {24'h0, rnd}, 4'hF);
		end
		bus(1'b1, abx_pkg::ADR_ACC, 32'h01, 4'hF);
		acc = 8'h01;
		ins({abx_pkg::PAT_ADD_LIT, 1'b0, 8'hFF});
		chkall(7'h00);
		// Unsupported opcode raises the sticky marker, a written one clears it
		bus(1'b1, abx_pkg::ADR_INSTR, 32'h0, 4'hF);
		rd(abx_pkg::ADR_STATUS, {27'h0, 1'b1, skp, z, dc, c});
		bus(1'b1, abx_pkg::ADR_STATUS, {27'h0, 1'b1, 1'b0, z, dc, c}, 4'hF);
		rd(abx_pkg::ADR_STATUS, {27'h0, 1'b0, skp, z, dc, c});
		rd(abx_pkg::ADR_ACC, {24'h0, acc});
		bus(1'b1, abx_pkg::ADR_ACC, 32'h5A, 4'h0);
		rd(abx_pkg::ADR_ACC, {24'h0, acc});
		for (int i = 0; i < 96; i++) begin
			rnd = nx(rnd);
			x = rnd;
			rnd = nx(rnd);
			f = fl[rnd[1:0]];
			case (i % 8)
				0: o = {abx_pkg::PAT_ADD_LIT, x[0], x};
				1: o = {abx_pkg::PAT_AND_LIT, x};
				2: o = {abx_pkg::PAT_ADD_FILE, x[7], f};
				3: o = {abx_pkg::PAT_AND_FILE, x[7], f};
				default: o = {abx_pkg::PAT_BIT_CLR + 4'(i % 8 - 4), x[2:0], f};
			endcase
			ins(o);
			chkall(f);
		end
		@(posedge core_clk);
		chk("reads left", 32'h0, q.size());
		print_verdict();
	end
endmodule // accumulator_bit_op_exec_test
`default_nettype wire
